// ### rtl/monitor_cfg_pkg.sv
/*
  Constants shared by the monitor register block and its serial slave:
  register offsets, reset values, field positions and timing counts.
  Assumes a 10 MHz core clock; the serial side runs on the host's clock.
*/
package monitor_cfg_pkg;
  // Core clock rate
  localparam int CLK_HZ = 10_000_000;
  // Register offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS1 = 8'h01;
  localparam logic [7:0] REG_STATUS2 = 8'h02;
  localparam logic [7:0] REG_MASK1 = 8'h03;
  localparam logic [7:0] REG_MASK2 = 8'h04;
  // Values after reset or initialisation
  localparam logic [7:0] CONFIG_RESET = 8'h08;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Configuration fields
  localparam int CFG_START = 0;
  localparam int CFG_ALERT_EN = 1;
  localparam int CFG_ALERT_POL = 2;
  localparam int CFG_ALERT_CLR = 3;
  localparam int CFG_RESET_PULSE = 4;
  localparam int CFG_CHASSIS_CLR = 5;
  localparam int CFG_GEN_OUT = 6;
  localparam int CFG_INIT = 7;
  // Second status and mask fields
  localparam int ST2_HOT = 0;
  localparam int ST2_BOARD = 1;
  localparam int ST2_FAN1 = 2;
  localparam int ST2_FAN2 = 3;
  localparam int ST2_CHASSIS = 4;
  localparam int ST2_OVERTEMP = 5;
  localparam int ST2_SOURCES = 6;
  localparam int MASK2_HOT_MODE = 6;
  localparam int MASK2_OT_MODE = 7;
  // Pulse output mode bits {bit7, bit6} of the fan divisor register
  localparam logic [1:0] PULSE_ALLOWED = 2'h2;
  // Fixed upper four bits of the slave address
  localparam logic [3:0] SLAVE_ADDR_HIGH = 4'h5;
  // Synchronised pin positions
  localparam int PIN_EXT = 0;
  localparam int PIN_BOARD = 1;
  localparam int PIN_CHASSIS = 2;
  // Link event positions
  localparam int LNK_WR = 0;
  localparam int LNK_RD = 1;
  localparam int LNK_HOLD = 2;
  // Times and derived cycle counts
  localparam int CHASSIS_CLEAR_MS = 10;
  localparam int CHASSIS_CLEAR_DEF_CYCLES = CHASSIS_CLEAR_MS * (CLK_HZ / 1000);
  localparam int RESET_PULSE_MS = 20;
  localparam int RESET_PULSE_DEF_CYCLES = RESET_PULSE_MS * (CLK_HZ / 1000);
endpackage

// ### rtl/mon_link_if.sv
/*
  Carrier between the serial slave (host clock) and the register core
  (core clock). Assumes words stay still while their toggle or level moves.
*/
interface mon_link_if;
  logic wr_toggle;      // Flips once per written data byte
  logic [7:0] ptr;      // Register pointer, steady during transfers
  logic [7:0] wr_data;  // Written byte, steady after its toggle
  logic rd_hold;        // High while a read frame wants a frozen value
  logic rd_done_toggle; // Flips once per byte shifted out to the host
  logic [7:0] rd_data;  // Frozen read value from the core
  modport link
  (
    output wr_toggle, ptr, wr_data, rd_hold, rd_done_toggle,
    input rd_data
  );
  modport core
  (
    input wr_toggle, ptr, wr_data, rd_hold, rd_done_toggle,
    output rd_data
  );
endinterface

// ### rtl/smbus_reg_slave.sv
/*
  Serial slave of the register block, clocked by the host clock line.
  Assumes the host clock stands still between frames and that the core
  freezes rd_data within a few core cycles of rd_hold rising.
*/
module smbus_reg_slave
  import monitor_cfg_pkg::*;
(
  // Link clock and reset
  input wire logic scl,
  input wire logic reset,
  // Data line, split into three signals
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address straps
  input wire logic [2:0] address_select_pins,
  // Towards the register core
  mon_link_if.link bus
);
  typedef enum logic [3:0]
  {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA, S_WDATA_ACK, S_RDATA, S_RACK
  } slave_state_e;

  slave_state_e state;     // Frame position
  logic sda_pos;           // Data sampled at the rising clock edge
  logic [2:0] addr_meta;   // Strap synchroniser, first stage
  logic [2:0] addr_sync;   // Strap synchroniser, second stage
  logic [2:0] cnt;         // Bit counter within a byte
  logic [7:0] shifter;     // Receive shift register
  logic [7:0] tx;          // Transmit shift register
  logic rw;                // Direction bit of the address byte
  logic stop_toggle;       // Flips on every stop condition
  logic stop_seen;         // Last stop toggle seen by the frame logic
  logic [7:0] next_byte;   // Byte completed by the current bit
  logic start;             // Start condition seen at this falling edge

  // Stop is data rising while the clock is high; no falling clock edge
  // follows it, so it is caught on the data edge and compared later
  always_ff @(posedge sda_in or posedge reset)
  begin
    if (reset)
      stop_toggle <= 1'b0;
    else if (scl)
      stop_toggle <= ~stop_toggle;
  end

  // Sample data and straps on the rising clock edge
  always_ff @(posedge scl or posedge reset)
  begin
    if (reset)
    begin
      sda_pos <= 1'b1;
      addr_meta <= 3'h0;
      addr_sync <= 3'h0;
    end
    else
    begin
      sda_pos <= sda_in;
      addr_meta <= address_select_pins;
      addr_sync <= addr_meta;
    end
  end

  assign next_byte = {shifter[6:0], sda_pos};
  // Data fell during the high phase, or a stop went before this edge
  assign start = !sda_in && (sda_pos || (stop_toggle != stop_seen));

  // Frame sequencer; all changes of the data line happen on falling edges
  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      cnt <= 3'h0;
      shifter <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      stop_seen <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      bus.ptr <= 8'h00;
      bus.wr_data <= 8'h00;
      bus.wr_toggle <= 1'b0;
      bus.rd_hold <= 1'b0;
      bus.rd_done_toggle <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      stop_seen <= stop_toggle;
      if (start)
      begin
        // A start, repeated or not, always restarts the frame
        state <= S_ADDR;
        cnt <= 3'h0;
        sda_oe_n <= 1'b1;
        bus.rd_hold <= 1'b0;
      end
      else
      begin
        unique case (state)
          S_IDLE:
            sda_oe_n <= 1'b1;
          S_ADDR:
          begin
            shifter <= next_byte;
            cnt <= cnt + 3'h1;
            // Answer only our own address
            if (cnt == 3'h7)
            begin
              if (next_byte[7:1] == {SLAVE_ADDR_HIGH, addr_sync})
              begin
                sda_oe_n <= 1'b0;
                rw <= next_byte[0];
                bus.rd_hold <= next_byte[0];
                state <= S_ADDR_ACK;
              end
              else
                state <= S_IDLE;
            end
          end
          S_ADDR_ACK:
          begin
            cnt <= 3'h0;
            if (rw)
            begin
              sda_oe_n <= bus.rd_data[7];
              tx <= {bus.rd_data[6:0], 1'b0};
              state <= S_RDATA;
            end
            else
            begin
              sda_oe_n <= 1'b1;
              state <= S_PTR;
            end
          end
          S_PTR:
          begin
            shifter <= next_byte;
            cnt <= cnt + 3'h1;
            // Second byte of a write selects the register
            if (cnt == 3'h7)
            begin
              bus.ptr <= next_byte;
              sda_oe_n <= 1'b0;
              state <= S_PTR_ACK;
            end
          end
          S_PTR_ACK, S_WDATA_ACK:
          begin
            sda_oe_n <= 1'b1;
            state <= S_WDATA;
          end
          S_WDATA:
          begin
            shifter <= next_byte;
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7)
            begin
              bus.wr_data <= next_byte;
              bus.wr_toggle <= ~bus.wr_toggle;
              sda_oe_n <= 1'b0;
              state <= S_WDATA_ACK;
            end
          end
          S_RDATA:
          begin
            if (cnt == 3'h7)
            begin
              sda_oe_n <= 1'b1;
              cnt <= 3'h0;
              state <= S_RACK;
            end
            else
            begin
              sda_oe_n <= tx[7];
              tx <= {tx[6:0], 1'b0};
              cnt <= cnt + 3'h1;
            end
          end
          S_RACK:
          begin
            // Each byte handed out counts as a read of the register
            bus.rd_done_toggle <= ~bus.rd_done_toggle;
            if (!sda_pos)
            begin
              sda_oe_n <= bus.rd_data[7];
              tx <= {bus.rd_data[6:0], 1'b0};
              state <= S_RDATA;
            end
            else
            begin
              bus.rd_hold <= 1'b0;
              state <= S_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

// ### rtl/monitor_config_interrupt_regs.sv
/*
  Configuration, alert status and alert mask registers of a hardware
  monitor, reached by the host over the serial slave.
  Assumes the limit comparators, fan counters and temperature logic run
  on clk and hand in their results as levels; the pins are asynchronous.
*/
module monitor_config_interrupt_regs
  import monitor_cfg_pkg::*;
#(
  parameter int CHASSIS_CLEAR_CYCLES = CHASSIS_CLEAR_DEF_CYCLES,
  parameter int RESET_PULSE_CYCLES = RESET_PULSE_DEF_CYCLES
)
(
  // Core clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link from the host
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] address_select_pins,
  // Fault levels from the monitoring logic, on clk
  input wire logic [6:0] analog_channel_flag,
  input wire logic hot_temp_violation,
  input wire logic [1:0] fan_limit_exceeded,
  input wire logic overtemp_violation,
  // Asynchronous event pins
  input wire logic external_alert_in_n,
  input wire logic board_temp_alert_in_n,
  input wire logic chassis_intrusion_in,
  // Pulse output mode, bits 7 and 6 of the fan divisor register
  input wire logic [1:0] reset_pulse_mode,
  // Alert pin, two signals
  output logic alert_out,
  output logic alert_oe_n,
  // Other outputs
  output logic reset_pulse_out_n,
  output logic general_output,
  output logic monitor_run,
  output logic chassis_intrusion_latched
);
  mon_link_if link();              // Carrier to the serial slave

  logic [2:0] pin_meta;            // Pin synchroniser, first stage
  logic [2:0] pin_sync;            // Pin synchroniser, second stage
  logic [2:0] pin_last;            // Previous synchronised pin levels
  logic [2:0] link_meta;           // Link crossing, first stage
  logic [2:0] link_sync;           // Link crossing, second stage
  logic [1:0] link_last;           // Previous toggle values
  logic wr_evt;                    // One-cycle pulse per written byte
  logic rd_evt;                    // One-cycle pulse per read byte
  logic hold;                      // Read value frozen while high
  logic [7:0] cfg;                 // Configuration register
  logic [7:0] st1;                 // First alert flag register
  logic [7:0] st2;                 // Second alert flag register
  logic [7:0] mask1;               // First alert mask register
  logic [7:0] mask2;               // Second alert mask register
  logic [7:0] snap;                // Frozen value handed to the slave
  logic [7:0] read_mux;            // Register addressed by the pointer
  logic cfg_wr;                    // Write to the configuration register
  logic init_now;                  // Write that restores every register
  logic run;                       // Monitoring is active
  logic hot_last;                  // Previous hot violation level
  logic ot_last;                   // Previous overtemp violation level
  logic [7:0] set1;                // Flags raised this cycle, first
  logic [7:0] set2;                // Flags raised this cycle, second
  logic [7:0] clr1;                // Flags cleared by a read, first
  logic [7:0] clr2;                // Flags cleared by a read, second
  logic pulse_active;              // Reset pulse in progress
  logic [31:0] pulse_timer;        // Cycles into the reset pulse
  logic pulse_start;               // Reset pulse begins
  logic pulse_end;                 // Pulse bit returns to zero
  logic chassis_active;            // Chassis clear window in progress
  logic [31:0] chassis_timer;      // Cycles into the clear window
  logic chassis_start;             // Chassis clear begins
  logic chassis_end;               // Chassis clear bit returns to zero
  logic chassis_rise;              // Chassis pin went high
  logic alert_pending;             // Some unmasked flag is set
  logic alert_active;              // Alert output should be asserted

  // The serial slave lives on the host clock
  smbus_reg_slave slave
  (
    .scl(scl),
    .reset(reset),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .address_select_pins(address_select_pins),
    .bus(link.link)
  );

  // Pins are asynchronous: two flops before any logic looks at them
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta <= 3'h3;
      pin_sync <= 3'h3;
      pin_last <= 3'h3;
    end
    else
    begin
      pin_meta <= {chassis_intrusion_in, board_temp_alert_in_n, external_alert_in_n};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Toggles and the hold level cross from the host clock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      link_meta <= 3'h0;
      link_sync <= 3'h0;
      link_last <= 2'h0;
    end
    else
    begin
      link_meta <= {link.rd_hold, link.rd_done_toggle, link.wr_toggle};
      link_sync <= link_meta;
      link_last <= link_sync[1:0];
    end
  end

  // Pointer and data words are steady well before their toggle arrives
  assign wr_evt = link_sync[LNK_WR] ^ link_last[LNK_WR];
  assign rd_evt = link_sync[LNK_RD] ^ link_last[LNK_RD];
  assign hold = link_sync[LNK_HOLD];
  assign cfg_wr = wr_evt && (link.ptr == REG_CONFIG);
  assign init_now = cfg_wr && link.wr_data[CFG_INIT];

  // Monitoring stops in shutdown and while alert clear is set
  assign run = cfg[CFG_START] && !cfg[CFG_ALERT_CLR];

  // Configuration register; the initialise bit never reads back as one
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cfg <= CONFIG_RESET;
    else if (init_now)
      cfg <= CONFIG_RESET;
    else if (cfg_wr)
      cfg <= link.wr_data;
    else
    begin
      // Self-clearing command bits
      if (pulse_end)
        cfg[CFG_RESET_PULSE] <= 1'b0;
      if (chassis_end)
        cfg[CFG_CHASSIS_CLR] <= 1'b0;
    end
  end

  // Mask registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mask1 <= MASK_RESET;
      mask2 <= MASK_RESET;
    end
    else if (init_now)
    begin
      mask1 <= MASK_RESET;
      mask2 <= MASK_RESET;
    end
    else if (wr_evt)
    begin
      if (link.ptr == REG_MASK1)
        mask1 <= link.wr_data;
      if (link.ptr == REG_MASK2)
        mask2 <= link.wr_data;
    end
  end

  // The pulse only fires with the pin in reset-output mode
  assign pulse_start = cfg_wr && !init_now && link.wr_data[CFG_RESET_PULSE]
                       && !pulse_active && (reset_pulse_mode == PULSE_ALLOWED);
  // A refused request drops the bit at once, as if its pulse had ended
  assign pulse_end = (pulse_active && (pulse_timer == 32'(RESET_PULSE_CYCLES - 1)))
                     || (cfg[CFG_RESET_PULSE] && !pulse_active);

  // Reset pulse timer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pulse_active <= 1'b0;
      pulse_timer <= 32'h0;
    end
    else if (init_now)
    begin
      pulse_active <= 1'b0;
      pulse_timer <= 32'h0;
    end
    else if (pulse_start)
    begin
      pulse_active <= 1'b1;
      pulse_timer <= 32'h0;
    end
    else if (pulse_active)
    begin
      if (pulse_timer == 32'(RESET_PULSE_CYCLES - 1))
        pulse_active <= 1'b0;
      else
        pulse_timer <= pulse_timer + 32'h1;
    end
  end

  // Chassis clear window; a second request inside it is absorbed
  assign chassis_start = cfg_wr && !init_now && link.wr_data[CFG_CHASSIS_CLR]
                         && !chassis_active;
  assign chassis_end = chassis_active && (chassis_timer == 32'(CHASSIS_CLEAR_CYCLES - 1));
  assign chassis_rise = pin_sync[PIN_CHASSIS] && !pin_last[PIN_CHASSIS];

  // Chassis clear timer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chassis_active <= 1'b0;
      chassis_timer <= 32'h0;
    end
    else if (chassis_start)
    begin
      chassis_active <= 1'b1;
      chassis_timer <= 32'h0;
    end
    else if (chassis_active)
    begin
      if (chassis_end)
        chassis_active <= 1'b0;
      else
        chassis_timer <= chassis_timer + 32'h1;
    end
  end

  // Latched intrusion state; a new intrusion beats a clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      chassis_intrusion_latched <= 1'b0;
    else if (chassis_rise)
      chassis_intrusion_latched <= 1'b1;
    else if (chassis_start)
      chassis_intrusion_latched <= 1'b0;
  end

  // Previous fault levels, for the one-time modes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hot_last <= 1'b0;
      ot_last <= 1'b0;
    end
    else
    begin
      hot_last <= hot_temp_violation;
      ot_last <= overtemp_violation;
    end
  end

  // Flag sources; monitored faults count only while monitoring runs
  always_comb
  begin
    set1 = 8'h00;
    set2 = 8'h00;
    set1[6:0] = run ? analog_channel_flag : 7'h00;
    set1[7] = !pin_sync[PIN_EXT];
    // Default mode sets while the fault lasts, one-time only on its onset
    if (mask2[MASK2_HOT_MODE])
      set2[ST2_HOT] = run && hot_temp_violation && !hot_last;
    else
      set2[ST2_HOT] = run && hot_temp_violation;
    set2[ST2_BOARD] = !pin_sync[PIN_BOARD];
    set2[ST2_FAN1] = run && fan_limit_exceeded[0];
    set2[ST2_FAN2] = run && fan_limit_exceeded[1];
    set2[ST2_CHASSIS] = chassis_rise;
    // Comparator mode follows the level, one-time mode only its onset
    if (mask2[MASK2_OT_MODE])
      set2[ST2_OVERTEMP] = run && overtemp_violation && !ot_last;
    else
      set2[ST2_OVERTEMP] = run && overtemp_violation;
  end

  // A read clears only what the host was shown, so later flags survive
  assign clr1 = (rd_evt && (link.ptr == REG_STATUS1)) ? snap : 8'h00;
  assign clr2 = (rd_evt && (link.ptr == REG_STATUS2)) ? snap : 8'h00;

  // Flag registers; a set in the clearing cycle wins, alert clear leaves them
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st1 <= STATUS_RESET;
      st2 <= STATUS_RESET;
    end
    else if (init_now)
    begin
      st1 <= STATUS_RESET;
      st2 <= STATUS_RESET;
    end
    else
    begin
      st1 <= (st1 & ~clr1) | set1;
      // Bits 6 and 7 are reserved and stay zero
      st2 <= ((st2 & ~clr2) | set2) & 8'h3F;
    end
  end

  // Register addressed by the pointer; unused offsets read zero
  always_comb
  begin
    case (link.ptr)
      REG_CONFIG: read_mux = cfg;
      REG_STATUS1: read_mux = st1;
      REG_STATUS2: read_mux = st2;
      REG_MASK1: read_mux = mask1;
      REG_MASK2: read_mux = mask2;
      default: read_mux = 8'h00;
    endcase
  end

  // Read value is frozen while a read frame runs, so bits never tear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      snap <= 8'h00;
    else if (!hold)
      snap <= read_mux;
  end
  assign link.rd_data = snap;

  // Alert decision from flags, masks, enable and clear
  assign alert_pending = |(st1 & ~mask1)
                         || |(st2[ST2_SOURCES-1:0] & ~mask2[ST2_SOURCES-1:0]);
  assign alert_active = cfg[CFG_ALERT_EN] && !cfg[CFG_ALERT_CLR]
                        && alert_pending;

  // Output flops; the alert drives only while active, in either style
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      alert_out <= 1'b0;
      alert_oe_n <= 1'b1;
      reset_pulse_out_n <= 1'b1;
      general_output <= 1'b1;
      monitor_run <= 1'b0;
    end
    else
    begin
      alert_out <= cfg[CFG_ALERT_POL];
      alert_oe_n <= !alert_active;
      reset_pulse_out_n <= !pulse_active;
      general_output <= !cfg[CFG_GEN_OUT];
      monitor_run <= run;
    end
  end
endmodule

// ### dv/monitor_checker.sv
/* Checker for the monitor register block, bound to its top module.
   Assumes the bench keeps the pulse mode steady while a pulse runs. */
module monitor_checker
  import monitor_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched pins
  input wire logic sda_out,
  input wire logic chassis_intrusion_in,
  input wire logic chassis_intrusion_latched,
  input wire logic [1:0] reset_pulse_mode,
  input wire logic reset_pulse_out_n,
  input wire logic alert_oe_n,
  input wire logic general_output,
  input wire logic monitor_run
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_reset_idle: assert property ($fell(reset) |-> alert_oe_n && general_output
    && !monitor_run && reset_pulse_out_n && !chassis_intrusion_latched)
    else $error("outputs not idle after reset");
  chk_pulse_mode: assert property ($fell(reset_pulse_out_n) |->
    $past(reset_pulse_mode) == PULSE_ALLOWED) else $error("pulse in wrong mode");
  chk_pulse_allowed: assert property (!reset_pulse_out_n |->
    reset_pulse_mode == PULSE_ALLOWED) else $error("pulse while not allowed");
  chk_pulse_width: assert property ($fell(reset_pulse_out_n) |->
    !reset_pulse_out_n [*8]) else $error("pulse too short");
  chk_pulse_ends: assert property ($fell(reset_pulse_out_n) |->
    ##[1:1000] reset_pulse_out_n) else $error("pulse never ends");
  chk_chassis_cause: assert property ($rose(chassis_intrusion_latched) |->
    $past(chassis_intrusion_in)) else $error("intrusion latched without cause");
  chk_chassis_sets: assert property ($rose(chassis_intrusion_in) |->
    ##[1:5] chassis_intrusion_latched) else $error("intrusion not latched");
  chk_data_low: assert property (sda_out == 1'b0)
    else $error("data line driven high");
endmodule
bind monitor_config_interrupt_regs monitor_checker monitor_checker_inst (.*);

// ### dv/smbus_host_model.sv
/* Host on the serial port: open-drain data with a pull-up.
   Assumes the device samples on rising and drives on falling edges. */
module smbus_host_model
(
  // Wire levels towards the device
  output logic scl,
  output logic sda,
  // Device drive of the data line
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_low = 1'b0; // Host pulls data low
  initial scl = 1'b1;
  // Pull-up wins unless some party pulls low
  assign sda = !(host_low || (!sda_oe_n && !sda_out));
  // One bit: 12 ns period, sampled while the clock is high
  task automatic clk_bit(input logic b, output logic r);
    host_low = !b;
    #3 scl = 1'b1;
    #3 r = sda;
    #3 scl = 1'b0;
    #3;
  endtask
  // Byte then ack slot; low phase stretched so the core can catch up
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], q[i]);
    #1000 clk_bit(1'b1, nak);
  endtask
  task automatic start_cond();
    host_low = 1'b0;
    #3 scl = 1'b1;
    #3 host_low = 1'b1;
    #6 scl = 1'b0;
  endtask
  task automatic stop_cond();
    host_low = 1'b1;
    #3 scl = 1'b1;
    #3 host_low = 1'b0;
    #1000;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
    output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    start_cond();
    xfer({a, 1'b0}, q, k[0]);
    xfer(p, q, k[1]);
    xfer(d, q, k[2]);
    stop_cond();
    ok = (k === 3'h0);
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
    output logic ok);
    logic [2:0] k;
    start_cond();
    xfer({a, 1'b0}, d, k[0]);
    xfer(p, d, k[1]);
    start_cond();
    xfer({a, 1'b1}, d, k[2]);
    xfer(8'hFF, d, k[0]);
    stop_cond();
    ok = (k[2:1] === 2'h0);
  endtask
endmodule

// ### dv/tb.sv
/* Top bench: host model on the serial port, fault inputs driven directly.
   Assumes address straps 3'h3 and short timer counts. */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import monitor_cfg_pkg::*;
  localparam logic [6:0] DEV = {SLAVE_ADDR_HIGH, 3'h3};
  logic clk = 1'b0;
  logic reset = 1'b0;
  logic [6:0] analog_channel_flag = 7'h00;
  logic external_alert_in_n = 1'b1;
  logic board_temp_alert_in_n = 1'b1;
  logic chassis_intrusion_in = 1'b0;
  logic [1:0] reset_pulse_mode = PULSE_ALLOWED;
  logic hot_temp_violation = 1'b0;
  logic overtemp_violation = 1'b0;
  logic [1:0] fan_limit_exceeded = 2'h0;
  logic scl, sda, sda_out, sda_oe_n, alert_out, alert_oe_n, reset_pulse_out_n;
  logic general_output, monitor_run, chassis_intrusion_latched, ok;
  logic [7:0] q;
  int fails = 0;
  int samples_checked = 0;
  int pulse_cycles = 0;
  always #50 clk = ~clk;
  // Length of the reset pulse in core cycles
  always @(posedge clk)
    if (!reset_pulse_out_n)
      pulse_cycles <= pulse_cycles + 1;
  monitor_config_interrupt_regs #(.CHASSIS_CLEAR_CYCLES(20), .RESET_PULSE_CYCLES(16))
    monitor_config_interrupt_regs_inst (.*, .sda_in(sda), .address_select_pins(3'h3));
  smbus_host_model smbus_host_model_inst (.*);
  task automatic finish_test();
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    smbus_host_model_inst.read_reg(DEV, p, q, ok);
    chk({ok, q}, {1'b1, exp});
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    smbus_host_model_inst.write_reg(DEV, p, d, ok);
    chk({8'h0, ok}, 9'h1);
  endtask
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("mismatch at %0t: timeout", $time);
    finish_test();
  end
  initial
  begin
    // Raised at time zero by a nonblocking write so every asynchronous reset sees an edge
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    smbus_host_model_inst.stop_cond();
    rd(REG_CONFIG, CONFIG_RESET);
    rd(REG_MASK2, MASK_RESET);
    smbus_host_model_inst.write_reg(7'h2C, REG_MASK1, 8'hFF, ok);
    chk({8'h0, ok}, 9'h0);
    rd(REG_MASK1, MASK_RESET);
    wr(REG_CONFIG, 8'h43);
    chk({7'h0, monitor_run, general_output}, 9'h2);
    @(posedge clk) analog_channel_flag <= 7'h05;
    @(posedge clk) analog_channel_flag <= 7'h00;
    repeat (4) @(posedge clk);
    chk({7'h0, alert_out, alert_oe_n}, 9'h0);
    rd(REG_STATUS1, 8'h05);
    chk({8'h0, alert_oe_n}, 9'h1);
    wr(REG_MASK1, 8'h80);
    @(posedge clk) external_alert_in_n <= 1'b0;
    @(posedge clk) external_alert_in_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({8'h0, alert_oe_n}, 9'h1);
    rd(REG_STATUS1, 8'h80);
    @(posedge clk) board_temp_alert_in_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({8'h0, alert_oe_n}, 9'h0);
    wr(REG_CONFIG, 8'h4F);
    chk({7'h0, monitor_run, alert_oe_n}, 9'h1);
    @(posedge clk) board_temp_alert_in_n <= 1'b1;
    rd(REG_STATUS2, 8'h02);
    wr(REG_CONFIG, 8'h47);
    @(posedge clk) chassis_intrusion_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk({6'h0, monitor_run, alert_out, alert_oe_n}, 9'h6);
    wr(REG_CONFIG, 8'h67);
    chk({8'h0, chassis_intrusion_latched}, 9'h0);
    rd(REG_CONFIG, 8'h47);
    wr(REG_MASK2, 8'h10);
    chk({8'h0, alert_oe_n}, 9'h1);
    rd(REG_STATUS2, 8'h10);
    wr(REG_MASK2, 8'hC0);
    @(posedge clk) {hot_temp_violation, overtemp_violation, fan_limit_exceeded} <= 4'hE;
    @(posedge clk) fan_limit_exceeded <= 2'h0;
    rd(REG_STATUS2, 8'h29);
    rd(REG_STATUS2, 8'h00);
    wr(REG_MASK2, 8'h00);
    rd(REG_STATUS2, 8'h21);
    wr(REG_CONFIG, 8'h17);
    rd(REG_CONFIG, 8'h07);
    chk(9'(pulse_cycles), 9'h10);
    wr(REG_CONFIG, 8'h80);
    rd(REG_MASK2, MASK_RESET);
    finish_test();
  end
endmodule
